// *** flut_pkg.sv ***
`default_nettype none
package flut_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] ADDR_LIMIT5 = 8'h58;
   localparam logic [7:0] ADDR_DUTY5  = 8'h59;
   localparam logic [7:0] ADDR_LIMIT6 = 8'h5A;
   localparam logic [7:0] ADDR_DUTY6  = 8'h5B;
   localparam logic [7:0] RST_LIMIT   = 8'h7F;
   localparam logic [7:0] RST_DUTY    = 8'h3F;
   localparam logic [7:0] READ_NONE   = 8'h00;
   // ==========================================
   // Field layout
   localparam int LIMIT_TOP_BIT = 7;
   localparam int DUTY_EXT_LSB  = 6;
   localparam logic [7:0] LIMIT_LOW_MASK = 8'h7F;
   localparam logic [7:0] DUTY_BASE_MASK = 8'h3F;
   localparam int NUM_REGS  = 4;
   localparam int IDX_LIMIT5 = 0;
   localparam int IDX_DUTY5  = 1;
   localparam int IDX_LIMIT6 = 2;
   localparam int IDX_DUTY6  = 3;
   // ==========================================
   // Mode carrier
   typedef struct packed {
      logic tempHiRes;
      logic dutyHiRes;
      logic pwmFast;
   } flut_mode_t;
   typedef struct packed {
      logic [7:0] tempInt;
      logic       tempHalf;
   } flut_temp_t;
endpackage : flut_pkg
`default_nettype wire

// *** flut_entry_pair.sv ***
`default_nettype none
// What this block does
// - Low temperature resolution: limit top bit unused, reads back zero.
// - High temperature resolution: top bit joins low seven bits as limit.
// - Limit spans 0 to 127.5 C high resolution, 0 to 127 C low.
// - Temperature above entry limit drives PWM with that entry's duty value, entry 6 taking precedence when both limits are exceeded.
// - Comparison uses nine temperature bits high resolution, eight bits low.
// - Limits are always positive; sign bit assumed zero.
// - Table offset register is added to limits to reach higher temperatures.
// - Low duty resolution: two upper duty bits unused, read back zero.
// - High duty resolution: upper two bits join lower six as PWM value.
// - Extended duty bits take effect only with 22.5 kHz PWM selected.
// - Low resolution PWM uses lower six duty bits as PWM value.
module flut_entry_pair #(
   parameter int TEMP_W = 8
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWrData,
   output var  logic [7:0]            regRdData,
   output var  logic                  regRdValid,
   input  wire flut_pkg::flut_mode_t  mode,
   input  wire flut_pkg::flut_temp_t  remoteTemp,
   input  wire logic [7:0]            lutTempOffset,
   input  wire logic [7:0]            lowerDuty,
   output var  logic [7:0]            pwmDuty,
   output var  logic [1:0]            entryHit
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Parameter check
   if (TEMP_W != 8)
   begin : gen_bad_width
      $error("flut_entry_pair supports only TEMP_W of 8");
   end

   // ==========================================
   // Register storage
   logic [7:0] regs      [flut_pkg::NUM_REGS];
   logic [7:0] next_regs [flut_pkg::NUM_REGS];
   logic [7:0] next_regRdData;
   logic       next_regRdValid;
   logic [7:0] next_pwmDuty;
   logic [1:0] next_entryHit;

   function automatic int addrIndex(input logic [7:0] a);
      if (a == flut_pkg::ADDR_LIMIT5)
      begin
         return flut_pkg::IDX_LIMIT5;
      end
      else if (a == flut_pkg::ADDR_DUTY5)
      begin
         return flut_pkg::IDX_DUTY5;
      end
      else if (a == flut_pkg::ADDR_LIMIT6)
      begin
         return flut_pkg::IDX_LIMIT6;
      end
      else if (a == flut_pkg::ADDR_DUTY6)
      begin
         return flut_pkg::IDX_DUTY6;
      end
      else
      begin
         return -1;
      end
   endfunction : addrIndex

   function automatic logic isDuty(input int idx);
      return (idx == flut_pkg::IDX_DUTY5) || (idx == flut_pkg::IDX_DUTY6);
   endfunction : isDuty

   // Visible value of a register under the current modes
   function automatic logic [7:0] visible(input int idx, input logic [7:0] v, input flut_pkg::flut_mode_t m);
      if (isDuty(idx))
      begin
         return m.dutyHiRes ? v : (v & flut_pkg::DUTY_BASE_MASK);
      end
      else
      begin
         return m.tempHiRes ? v : (v & flut_pkg::LIMIT_LOW_MASK);
      end
   endfunction : visible

   // Limit in half degrees plus offset, ten bits
   function automatic logic [9:0] limitHalf(input logic [7:0] lim, input logic [7:0] off,
                                            input logic hi);
      logic [9:0] offH;
      offH = {1'b0, off, 1'b0};
      if (hi)
      begin
         return offH + {2'b00, lim};
      end
      else
      begin
         return offH + {1'b0, lim & flut_pkg::LIMIT_LOW_MASK, 1'b0};
      end
   endfunction : limitHalf

   // Effective PWM value of a duty register
   function automatic logic [7:0] dutyValue(input logic [7:0] d, input flut_pkg::flut_mode_t m);
      if (m.dutyHiRes && m.pwmFast)
      begin
         return d;
      end
      else
      begin
         return d & flut_pkg::DUTY_BASE_MASK;
      end
   endfunction : dutyValue

   // ==========================================
   // Register bank
   int wIdx;
   always_comb
   begin
      wIdx = addrIndex(regAddr);
      for (int i = 0; i < flut_pkg::NUM_REGS; i++)
      begin
         next_regs[i] = regs[i];
      end
      if (regWrite && (wIdx >= 0))
      begin
         next_regs[wIdx] = regWrData;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         regs[flut_pkg::IDX_LIMIT5] <= flut_pkg::RST_LIMIT;
         regs[flut_pkg::IDX_DUTY5]  <= flut_pkg::RST_DUTY;
         regs[flut_pkg::IDX_LIMIT6] <= flut_pkg::RST_LIMIT;
         regs[flut_pkg::IDX_DUTY6]  <= flut_pkg::RST_DUTY;
      end
      else
      begin
         for (int i = 0; i < flut_pkg::NUM_REGS; i++)
         begin
            regs[i] <= next_regs[i];
         end
      end
   end

   // ==========================================
   // Read port
   int rIdx;
   always_comb
   begin
      rIdx            = addrIndex(regAddr);
      next_regRdValid = regRead;
      next_regRdData  = regRdData;
      if (regRead && (rIdx >= 0))
      begin
         next_regRdData = visible(rIdx, regs[rIdx], mode);
      end
      else if (regRead)
      begin
         next_regRdData = flut_pkg::READ_NONE;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         regRdData  <= flut_pkg::READ_NONE;
         regRdValid <= 1'b0;
      end
      else
      begin
         regRdData  <= next_regRdData;
         regRdValid <= next_regRdValid;
      end
   end

   // ==========================================
   // Fan duty selection
   localparam int NUM_ENTRIES = 2;
   localparam int LIMIT_STEP  = flut_pkg::IDX_LIMIT6 - flut_pkg::IDX_LIMIT5;
   logic [9:0]             tempH;
   logic [NUM_ENTRIES-1:0] hit;

   // Nine bits high resolution, eight bits low resolution
   assign tempH = mode.tempHiRes ? {1'b0, remoteTemp.tempInt, remoteTemp.tempHalf}
                                 : {1'b0, remoteTemp.tempInt, 1'b0};

   for (genvar e = 0; e < NUM_ENTRIES; e++)
   begin : gen_entry
      localparam int LIM_IDX = flut_pkg::IDX_LIMIT5 + e * LIMIT_STEP;
      assign hit[e] = tempH > limitHalf(regs[LIM_IDX], lutTempOffset, mode.tempHiRes);
   end

   always_comb
   begin
      next_entryHit = hit;
      if (hit[1])
      begin
         next_pwmDuty = dutyValue(regs[flut_pkg::IDX_DUTY6], mode);
      end
      else if (hit[0])
      begin
         next_pwmDuty = dutyValue(regs[flut_pkg::IDX_DUTY5], mode);
      end
      else
      begin
         next_pwmDuty = lowerDuty;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pwmDuty  <= flut_pkg::READ_NONE;
         entryHit <= 2'b00;
      end
      else
      begin
         pwmDuty  <= next_pwmDuty;
         entryHit <= next_entryHit;
      end
   end
endmodule : flut_entry_pair
`default_nettype wire

// *** flut_assertions.sv ***
`default_nettype none
module flut_assertions (
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire logic                 regWrite,
   input wire logic                 regRead,
   input wire logic [7:0]           regAddr,
   input wire logic [7:0]           regWrData,
   input wire logic [7:0]           regRdData,
   input wire logic                 regRdValid,
   input wire flut_pkg::flut_mode_t mode,
   input wire flut_pkg::flut_temp_t remoteTemp,
   input wire logic [7:0]           lutTempOffset,
   input wire logic [7:0]           lowerDuty,
   input wire logic [7:0]           pwmDuty,
   input wire logic [1:0]           entryHit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RD_TIME:
      assert property (!$past(rst) |-> regRdValid == $past(regRead)) else $error("read valid timing");
   AST_UNMAPPED:
      assert property (regRead && regAddr[7:2] != 6'h16 |=> regRdData == 8'h00) else $error("unmapped read");
   AST_LIMIT_RD:
      assert property (regRdValid && !$past(mode.tempHiRes) && !$past(regAddr[0]) |-> !regRdData[7])
      else $error("limit top bit");
   AST_DUTY_RD:
      assert property (regRdValid && !$past(mode.dutyHiRes) && $past(regAddr[0]) |-> regRdData[7:6] == 2'h0)
      else $error("duty upper bits");
   AST_NO_HIT:
      assert property (!$past(rst) && entryHit == 2'h0 |-> pwmDuty == $past(lowerDuty)) else $error("pass duty");
   AST_EXT_GATE:
      assert property (entryHit != 2'h0 && !($past(mode.pwmFast) && $past(mode.dutyHiRes)) |-> pwmDuty[7:6] == 2'h0)
      else $error("ext duty gate");
   AST_ZERO:
      assert property (remoteTemp == 9'h000 |=> entryHit == 2'h0) else $error("zero temp hit");
   AST_MAX:
      assert property (remoteTemp == 9'h1FF && lutTempOffset == 8'h00 |=> entryHit == 2'h3) else $error("max temp");
endmodule : flut_assertions
bind flut_entry_pair flut_assertions i_chk (
   .ref_clk       (ref_clk),
   .rst           (rst),
   .regWrite      (regWrite),
   .regRead       (regRead),
   .regAddr       (regAddr),
   .regWrData     (regWrData),
   .regRdData     (regRdData),
   .regRdValid    (regRdValid),
   .mode          (mode),
   .remoteTemp    (remoteTemp),
   .lutTempOffset (lutTempOffset),
   .lowerDuty     (lowerDuty),
   .pwmDuty       (pwmDuty),
   .entryHit      (entryHit)
);
`default_nettype wire

// *** tb_flut_entry_pair.sv ***
`default_nettype none
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_flut_entry_pair;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst = 1, regWrite = 0, regRead = 0, regRdValid;
   logic [7:0] regAddr = 0, regWrData = 0, regRdData, lutTempOffset = 0, lowerDuty = 8'h11, pwmDuty;
   logic [1:0] entryHit;
   flut_pkg::flut_mode_t mode = 0;
   flut_pkg::flut_temp_t remoteTemp = 0;
   int miscompares = 0, num_checks = 0, cyc = 0;
   flut_entry_pair i_dut (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .regWrite      (regWrite),
      .regRead       (regRead),
      .regAddr       (regAddr),
      .regWrData     (regWrData),
      .regRdData     (regRdData),
      .regRdValid    (regRdValid),
      .mode          (mode),
      .remoteTemp    (remoteTemp),
      .lutTempOffset (lutTempOffset),
      .lowerDuty     (lowerDuty),
      .pwmDuty       (pwmDuty),
      .entryHit      (entryHit)
   );
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cyc == 2000) begin miscompares++; close_out(); end
   task close_out;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   task wr(input logic [7:0] a, input logic [7:0] d);
      regWrite  = 1'b1;
      regAddr   = a;
      regWrData = d;
      @(posedge ref_clk);
      #1;
      regWrite  = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      regRead = 1'b1;
      regAddr = a;
      @(posedge ref_clk);
      #1;
      regRead = 1'b0;
      `CHK("valid", 1'b1, regRdValid)
      `CHK("rdata", e, regRdData)
      @(posedge ref_clk);
      #1;
   endtask : rd
   task fan(input logic [2:0] m, input logic [8:0] t, input logic [7:0] o, input logic [1:0] h, input logic [7:0] p);
      mode = m; remoteTemp = t; lutTempOffset = o;
      @(posedge ref_clk); #1;
      `CHK("hit", h, entryHit)
      `CHK("pwm", p, pwmDuty)
   endtask : fan
   task t_regs;
      mode = 3'h7;
      rd(8'h58, 8'h7F);
      rd(8'h59, 8'h3F);
      rd(8'h5A, 8'h7F);
      rd(8'h5B, 8'h3F);
      wr(8'h58, 8'h20);
      wr(8'h59, 8'h2A);
      wr(8'h5A, 8'h90);
      wr(8'h5B, 8'hC5);
      rd(8'h5A, 8'h90);
      rd(8'h5B, 8'hC5);
      mode = 3'h0;
      rd(8'h5A, 8'h10);
      rd(8'h5B, 8'h05);
      rd(8'h5C, 8'h00);
      wr(8'h5C, 8'hFF);
      rd(8'h58, 8'h20);
      $display("test regs done");
   endtask : t_regs
   task t_fan;
      fan(3'h2, {8'h0A, 1'b0}, 8'h00, 2'h0, 8'h11);
      fan(3'h2, {8'h14, 1'b0}, 8'h00, 2'h2, 8'h05);
      fan(3'h3, {8'h14, 1'b0}, 8'h00, 2'h2, 8'hC5);
      fan(3'h1, {8'h14, 1'b0}, 8'h00, 2'h2, 8'h05);
      fan(3'h7, {8'h14, 1'b0}, 8'h00, 2'h1, 8'h2A);
      fan(3'h7, {8'h48, 1'b0}, 8'h00, 2'h1, 8'h2A);
      fan(3'h7, {8'h48, 1'b1}, 8'h00, 2'h3, 8'hC5);
      fan(3'h7, {8'h50, 1'b0}, 8'h0A, 2'h1, 8'h2A);
      fan(3'h7, 9'h000, 8'h00, 2'h0, 8'h11);
      fan(3'h7, 9'h1FF, 8'h00, 2'h3, 8'hC5);
      $display("test fan done");
   endtask : t_fan
   initial
   begin
      repeat (8) @(posedge ref_clk);
      #1 rst = 0;
      t_regs();
      t_fan();
      close_out();
   end
endmodule : tb_flut_entry_pair
`default_nettype wire
